// File: scp_pwm.sv
// Six-output pulse-width modulator with capture, trap, burst and sync chain
module scp_pwm #(
	parameter int NCH = scp_pkg::N_OUT,
	parameter int NCAP = scp_pkg::N_CAP,
	parameter int CW = scp_pkg::CNT_W
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run_enable,
	input wire logic run_once_mode,
	input wire logic slave_mode,
	input wire logic burst_enable,
	input wire logic update_request,
	input wire logic [CW-1:0] period_value,
	input wire logic [CW-1:0] prescale_value,
	input wire logic [NCH-1:0][CW-1:0] rise_value,
	input wire logic [NCH-1:0][CW-1:0] fall_value,
	input wire logic [CW-1:0] sync_delay,
	input wire logic [NCH-1:0] trap_level,
	input wire logic trap_clear,
	input wire logic [NCH-1:0] rise_event_en,
	input wire logic [NCH-1:0] fall_event_en,
	input wire logic [NCAP-1:0] capture_event_en,
	input wire logic overflow_event_en,
	input wire logic trap_event_en,
	input wire logic [NCAP-1:0] capture_input_pins,
	input wire logic protective_hold_input,
	input wire logic carrier_input,
	input wire logic sync_in,
	input wire logic trans_enable_in,
	output logic [NCH-1:0] modulated_output_pins,
	output logic sync_out,
	output logic trans_enable_out,
	output logic [NCH-1:0] rise_match_event,
	output logic [NCH-1:0] fall_match_event,
	output logic [NCAP-1:0] capture_event,
	output logic overflow_event,
	output logic trap_event,
	output logic [NCAP-1:0][CW-1:0] capture_values,
	output logic [CW-1:0] period_count,
	output logic running_status,
	output logic trap_active,
	output logic update_pending
);

	// ********************************
	// Parameter check
	// ********************************
	generate
		if (NCH < 1 || NCAP < 1 || CW != scp_pkg::CNT_W) begin : g_bad_params
			$error("scp_pwm: unsupported parameter values");
		end
	endgenerate

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic [NCAP-1:0] cap_s1;
		logic [NCAP-1:0] cap_s2;
		logic [NCAP-1:0] cap_prev;
		logic trap_s1;
		logic trap_s2;
		logic car_s1;
		logic car_s2;
		logic running;
		logic done;
		logic pend;
		logic [CW-1:0] psc;
		logic [CW-1:0] cnt;
		logic [CW-1:0] per_sh;
		logic [CW-1:0] psc_sh;
		logic [NCH-1:0][CW-1:0] rise_sh;
		logic [NCH-1:0][CW-1:0] fall_sh;
		logic [NCH-1:0] wave;
		logic trap_on;
		logic dly_pend;
		logic dly_load;
		logic [CW-1:0] dly_cnt;
		logic [NCH-1:0] outp;
		logic sync_o;
		logic trans_o;
		logic [NCH-1:0] rise_ev;
		logic [NCH-1:0] fall_ev;
		logic [NCAP-1:0] cap_ev;
		logic ovf_ev;
		logic trap_ev;
		logic [NCAP-1:0][CW-1:0] cap_val;
	} scp_state_s;

	scp_state_s state_reg;
	scp_state_s state_next;

	// ********************************
	// Next-state logic
	// ********************************
	always_comb begin
		logic tick;
		logic restart;
		logic loaded;
		tick = 1'b0;
		restart = 1'b0;
		loaded = 1'b0;
		state_next = state_reg;
		state_next.rise_ev = '0;
		state_next.fall_ev = '0;
		state_next.cap_ev = '0;
		state_next.ovf_ev = 1'b0;
		state_next.trap_ev = 1'b0;
		state_next.sync_o = 1'b0;
		state_next.trans_o = 1'b0;
		// Input synchronisers
		state_next.cap_s1 = capture_input_pins;
		state_next.cap_s2 = state_reg.cap_s1;
		state_next.cap_prev = state_reg.cap_s2;
		state_next.trap_s1 = protective_hold_input;
		state_next.trap_s2 = state_reg.trap_s1;
		state_next.car_s1 = carrier_input;
		state_next.car_s2 = state_reg.car_s1;
		// Counter chain on the shared module clock
		if (state_reg.running) begin
			if (state_reg.psc == state_reg.psc_sh) begin
				state_next.psc = scp_pkg::CNT_ZERO;
				tick = 1'b1;
			end else begin
				state_next.psc = state_reg.psc + scp_pkg::CNT_ONE;
			end
		end
		if (tick) begin
			if (state_reg.cnt == state_reg.per_sh) begin
				state_next.cnt = scp_pkg::CNT_ZERO;
				state_next.ovf_ev = overflow_event_en;
				if (run_once_mode) begin
					state_next.running = 1'b0;
					state_next.done = 1'b1;
				end else begin
					restart = 1'b1;
				end
			end else begin
				state_next.cnt = state_reg.cnt + scp_pkg::CNT_ONE;
			end
		end
		if (!state_reg.running && !state_reg.done && run_enable) begin
			state_next.running = 1'b1;
			restart = 1'b1;
		end
		if (!run_enable) begin
			state_next.running = 1'b0;
			state_next.done = 1'b0;
		end
		// Slave follows the neighbouring master
		if (slave_mode && sync_in && run_enable) begin
			state_next.running = 1'b1;
			state_next.done = 1'b0;
			restart = 1'b1;
		end
		if (restart) begin
			state_next.cnt = scp_pkg::CNT_ZERO;
			state_next.psc = scp_pkg::CNT_ZERO;
		end
		// Shadow transfer only at restart or on chain pulse
		if (slave_mode ? trans_enable_in : (restart && state_reg.pend)) begin
			state_next.per_sh = period_value;
			state_next.psc_sh = prescale_value;
			state_next.rise_sh = rise_value;
			state_next.fall_sh = fall_value;
			state_next.pend = 1'b0;
			loaded = restart;
		end
		if (update_request) begin
			state_next.pend = 1'b1;
		end
		// Delayed chain pulses
		if (state_reg.dly_pend) begin
			if (state_reg.dly_cnt == scp_pkg::CNT_ZERO) begin
				state_next.dly_pend = 1'b0;
				state_next.sync_o = 1'b1;
				state_next.trans_o = state_reg.dly_load;
			end else begin
				state_next.dly_cnt = state_reg.dly_cnt - scp_pkg::CNT_ONE;
			end
		end
		if (restart) begin
			state_next.dly_pend = 1'b1;
			state_next.dly_load = loaded;
			state_next.dly_cnt = sync_delay;
		end
		// Edge matches per output
		if (tick || restart) begin
			for (int i = 0; i < NCH; i++) begin
				if (state_next.cnt == state_next.rise_sh[i]) begin
					state_next.wave[i] = 1'b1;
					state_next.rise_ev[i] = rise_event_en[i];
				end
				if (state_next.cnt == state_next.fall_sh[i]) begin
					state_next.wave[i] = 1'b0;
					state_next.fall_ev[i] = fall_event_en[i];
				end
			end
		end
		// Capture on rising edge of a synchronised pin
		for (int k = 0; k < NCAP; k++) begin
			if (state_reg.cap_s2[k] && !state_reg.cap_prev[k]) begin
				state_next.cap_val[k] = state_reg.cnt;
				state_next.cap_ev[k] = capture_event_en[k];
			end
		end
		// Trap latch, a new trap wins over the clear
		if (trap_clear) begin
			state_next.trap_on = 1'b0;
		end
		if (state_reg.trap_s2) begin
			state_next.trap_on = 1'b1;
			state_next.trap_ev = trap_event_en && !state_reg.trap_on;
		end
		// Output mixing
		if (state_next.trap_on) begin
			state_next.outp = trap_level;
		end else if (burst_enable) begin
			state_next.outp = state_next.wave & {NCH{state_reg.car_s2}};
		end else begin
			state_next.outp = state_next.wave;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign modulated_output_pins = state_reg.outp;
	assign sync_out = state_reg.sync_o;
	assign trans_enable_out = state_reg.trans_o;
	assign rise_match_event = state_reg.rise_ev;
	assign fall_match_event = state_reg.fall_ev;
	assign capture_event = state_reg.cap_ev;
	assign overflow_event = state_reg.ovf_ev;
	assign trap_event = state_reg.trap_ev;
	assign capture_values = state_reg.cap_val;
	assign period_count = state_reg.cnt;
	assign running_status = state_reg.running;
	assign trap_active = state_reg.trap_on;
	assign update_pending = state_reg.pend;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_wrap_no_delay;
		overflow_event && running_status && $past(sync_delay) == scp_pkg::CNT_ZERO;
	endsequence

	sequence s_rise_only;
		rise_match_event[0] && !fall_match_event[0] && !trap_active && !burst_enable;
	endsequence

	a_sync_one_cycle: assert property (sync_out |=> !sync_out)
		else $error("period-start pulse longer than one cycle");
	a_trans_with_sync: assert property (trans_enable_out |-> sync_out)
		else $error("shadow-loaded pulse without period-start pulse");
	a_zero_delay_sync: assert property (s_wrap_no_delay |=> sync_out)
		else $error("period-start pulse missing after restart");
	a_count_in_range: assert property (running_status |-> period_count <= state_reg.per_sh)
		else $error("period counter above period value");
	a_overflow_wrap: assert property (overflow_event |-> period_count == scp_pkg::CNT_ZERO)
		else $error("overflow without wrap to zero");
	a_once_stops: assert property ($past(run_once_mode) && overflow_event |-> !running_status)
		else $error("run-once did not stop");
	a_rise_drives: assert property (s_rise_only |-> modulated_output_pins[0])
		else $error("output not high after rising match");
	a_trap_levels: assert property (trap_active |-> modulated_output_pins == $past(trap_level))
		else $error("trap levels not held");
	a_capture_latch: assert property (capture_event[0] |-> capture_values[0] == $past(period_count))
		else $error("capture value mismatch");

	// ********************************
	// Further checks
	// ********************************
	sequence s_burst_dark;
		$past(burst_enable) && !$past(state_reg.car_s2) && !trap_active;
	endsequence

	sequence s_slave_start;
		slave_mode && sync_in && run_enable;
	endsequence

	sequence s_slave_load;
		slave_mode && trans_enable_in && !update_request;
	endsequence

	sequence s_fresh_start;
		!running_status && !state_reg.done && run_enable;
	endsequence

	a_burst_mask: assert property (s_burst_dark |-> modulated_output_pins == '0)
		else $error("burst carrier low but outputs active");
	a_slave_restart: assert property (s_slave_start |=> period_count == '0)
		else $error("slave did not restart on chain pulse");
	a_slave_shadow: assert property (s_slave_load |=> !update_pending)
		else $error("slave shadow load left update pending");
	a_start_zero: assert property (s_fresh_start |=> running_status && period_count == '0)
		else $error("start did not clear the counter");
	a_trap_entry: assert property (trap_event |-> trap_active)
		else $error("trap event without trap state");
	a_trap_gated: assert property (trap_event |-> $past(trap_event_en))
		else $error("trap event while disabled");
	a_rise_gated: assert property (rise_match_event[0] |-> $past(rise_event_en[0]))
		else $error("rise event while disabled");
	a_fall_gated: assert property (fall_match_event[0] |-> $past(fall_event_en[0]))
		else $error("fall event while disabled");
	a_capture_gated: assert property (capture_event[0] |-> $past(capture_event_en[0]))
		else $error("capture event while disabled");
	a_overflow_gated: assert property (overflow_event |-> $past(overflow_event_en))
		else $error("overflow event while disabled");

endmodule

// File: scp_pkg.sv
// Shared constants for the six-output modulator
package scp_pkg;
	localparam int CNT_W = 16;
	localparam int N_OUT = 6;
	localparam int N_CAP = 3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage

// File: scp_master_model.sv
// Neighbouring master model driving the chain pulses
module scp_master_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic with_load,
	output logic sync_pulse,
	output logic load_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Pulses follow fire one cycle later
	// ****************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_pulse <= 1'h0;
			load_pulse <= 1'h0;
		end else begin
			sync_pulse <= fire;
			load_pulse <= fire & with_load;
		end
	end
endmodule

// File: test_six_channel_pwm_with_sync.sv
// Self-checking bench for the six-output modulator
module test_six_channel_pwm_with_sync;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [15:0] per, psc, dly, span;} scp_row_s;
	scp_row_s rows[3] = '{'{16'h0002, 16'h0000, 16'h0000, 16'h0003},
		'{16'h0005, 16'h0001, 16'h0003, 16'h000C}, '{16'h0003, 16'h0002, 16'h0001, 16'h000C}};
	logic clock = 1'h0, rst_n = 1'h0, run_enable = 1'h0, run_once_mode = 1'h0, fire = 1'h0;
	logic slave_mode = 1'h0, burst_enable = 1'h0, update_request = 1'h0, trap_clear = 1'h0;
	logic protective_hold_input = 1'h0, carrier_input = 1'h1, with_load = 1'h1;
	logic [15:0] period_value = 16'h0000, prescale_value = 16'h0000, sync_delay = 16'h0000;
	logic [5:0][15:0] rise_value, fall_value;
	logic [5:0] trap_level = 6'h2D, modulated_output_pins, rise_match_event, fall_match_event;
	logic [2:0] capture_input_pins = 3'h0, capture_event;
	logic [2:0][15:0] capture_values;
	logic [15:0] period_count, c;
	logic sync_in, trans_enable_in, sync_out, trans_enable_out, overflow_event, trap_event;
	logic running_status, trap_active, update_pending;
	logic [3:0] seen;
	int error_cnt = 0, checks = 0;
	always #50 clock = ~clock;
	always @(posedge clock) seen <= rst_n ? (seen | {trap_event, capture_event}) : 4'h0;
	scp_pwm u_dut (.clock, .rst_n, .run_enable, .run_once_mode, .slave_mode, .burst_enable,
		.update_request, .period_value, .prescale_value, .rise_value, .fall_value, .sync_delay,
		.trap_level, .trap_clear, .rise_event_en(6'h3F), .fall_event_en(6'h3F),
		.capture_event_en(3'h7), .overflow_event_en(1'h1), .trap_event_en(1'h1),
		.capture_input_pins, .protective_hold_input, .carrier_input, .sync_in, .trans_enable_in,
		.modulated_output_pins, .sync_out, .trans_enable_out, .rise_match_event,
		.fall_match_event, .capture_event, .overflow_event, .trap_event, .capture_values,
		.period_count, .running_status, .trap_active, .update_pending);
	scp_master_model u_master (.clock, .rst_n, .fire, .with_load, .sync_pulse(sync_in),
		.load_pulse(trans_enable_in));
	// ***************
	// Helpers
	// ***************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wait_run(input logic lvl);
		int n;
		n = 0;
		while (running_status !== lvl && n < 50) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 50) begin
			error_cnt++;
			report_and_stop;
		end
	endtask
	function automatic logic [5:0] pat(input logic [15:0] v);
		for (int ch = 0; ch < 6; ch++) begin
			pat[ch] = (rise_value[ch] < fall_value[ch]) ? (v >= rise_value[ch] && v < fall_value[ch])
				: (v >= rise_value[ch] || v < fall_value[ch]);
		end
	endfunction
	// ***************
	// Main sequence
	// ***************
	initial begin
		for (int ch = 0; ch < 6; ch++) begin
			rise_value[ch] = 16'(ch % 3);
			fall_value[ch] = 16'((ch + 1 + ch / 3) % 3);
		end
		repeat (8) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		#1;
		chk(modulated_output_pins, 6'h00, "reset pins");
		chk(period_count, 16'h0000, "reset count");
		foreach (rows[i]) begin
			@(posedge clock);
			period_value <= rows[i].per;
			prescale_value <= rows[i].psc;
			sync_delay <= rows[i].dly;
			update_request <= 1'h1;
			@(posedge clock);
			update_request <= 1'h0;
			run_enable <= 1'h1;
			wait_run(1'h1);
			for (int j = 0; j < 2 * rows[i].span; j++) begin
				c = 16'(j / (rows[i].psc + 1) % (rows[i].per + 1));
				chk(period_count, c, "count");
				chk(overflow_event, j > 0 && j % rows[i].span == 0, "overflow");
				if (j < rows[i].span) chk(sync_out, j == rows[i].dly + 1, "sync");
				if (j < rows[i].span) chk(trans_enable_out, j == rows[i].dly + 1, "load");
				if (j == 0) chk(update_pending, 1'h0, "pending");
				if (j >= rows[i].span) chk(modulated_output_pins, pat(c), "pins");
				@(posedge clock);
				#1;
			end
			run_enable <= 1'h0;
		end
		@(posedge clock);
		run_once_mode <= 1'h1;
		run_enable <= 1'h1;
		wait_run(1'h1);
		wait_run(1'h0);
		chk(period_count, 16'h0000, "once stop");
		run_enable <= 1'h0;
		run_once_mode <= 1'h0;
		@(posedge clock);
		run_enable <= 1'h1;
		capture_input_pins <= 3'h7;
		burst_enable <= 1'h1;
		carrier_input <= 1'h0;
		repeat (6) @(posedge clock);
		#1;
		chk(modulated_output_pins, 6'h00, "burst");
		chk(seen, 4'h7, "capture");
		burst_enable <= 1'h0;
		protective_hold_input <= 1'h1;
		trap_clear <= 1'h1;
		repeat (6) @(posedge clock);
		#1;
		chk(trap_active, 1'h1, "trap");
		chk(modulated_output_pins, trap_level, "trap pins");
		chk(seen, 4'hF, "trap event");
		protective_hold_input <= 1'h0;
		repeat (6) @(posedge clock);
		#1;
		chk(trap_active, 1'h0, "trap clear");
		trap_clear <= 1'h0;
		slave_mode <= 1'h1;
		repeat (4) @(posedge clock);
		fire <= 1'h1;
		@(posedge clock);
		fire <= 1'h0;
		@(posedge clock);
		#1;
		chk(period_count, 16'h0000, "slave restart");
		report_and_stop;
	end
endmodule
